/* File: hdl/port_irq_lb.sv */
`timescale 1ns/1ns
// Behaviour
// - Status bit 1 follows pending PHY interrupt; always 0 without PHY.
// - ACL counter-mode interrupt event sets status bit 0.
// - ACL status clears only when software toggles the ACL mask bit.
// - Mask bits are read/write, reset 0; 0 enables, 1 disables a cause.
// - ACL mask acts on every port; PHY mask matters only with PHY.
// - Port status reports only port causes; other bits read zero.
// - Control bit 7 loops fabric egress traffic back into the fabric.
// - Control bit 6 returns pin receive frames out the same port, bypassing fabric.
// - Remote loop returns line receive data onto line transmit data.
module port_irq_lb #(
  parameter bit HAS_PHY = 1'b1,
  parameter int DW = 8
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_q,
  input wire logic phy_irq,
  input wire logic acl_irq_pulse,
  output logic port_irq_q,
  output logic tail_tag_en_q,
  input wire logic [DW-1:0] fabric_tx_data,
  input wire logic fabric_tx_valid,
  output logic [DW-1:0] fabric_rx_data_q,
  output logic fabric_rx_valid_q,
  input wire logic [DW-1:0] line_rx_data,
  input wire logic line_rx_valid,
  output logic [DW-1:0] line_tx_data_q,
  output logic line_tx_valid_q
);

  typedef struct packed {
    logic [7:0] rdata;
    logic acl_st;
    logic phy_st;
    logic mask_acl;
    logic mask_phy;
    logic lb_local;
    logic lb_remote;
    logic tail_tag;
    logic irq;
    logic [DW-1:0] rx_s1;
    logic [DW-1:0] rx_s2;
    logic rxv_s1;
    logic rxv_s2;
    logic [DW-1:0] ltx;
    logic ltx_v;
    logic [DW-1:0] frx;
    logic frx_v;
  } state_t;

  state_t s_q;
  state_t s_d;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  logic mask_wr;
  logic [7:0] status_view;
  logic [7:0] mask_view;
  logic [7:0] ctrl_view;

  assign mask_wr = reg_wr && hit(reg_addr, port_irq_lb_pkg::MASK_OFS);

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    status_view = port_irq_lb_pkg::STATUS_RST;
    status_view[port_irq_lb_pkg::ACL_BIT] = s_q.acl_st;
    status_view[port_irq_lb_pkg::PHY_BIT] = s_q.phy_st;
    mask_view = port_irq_lb_pkg::MASK_RST;
    mask_view[port_irq_lb_pkg::ACL_BIT] = s_q.mask_acl;
    mask_view[port_irq_lb_pkg::PHY_BIT] = s_q.mask_phy;
    ctrl_view = port_irq_lb_pkg::CTRL0_RST;
    ctrl_view[port_irq_lb_pkg::LOCAL_LB_BIT] = s_q.lb_local;
    ctrl_view[port_irq_lb_pkg::REMOTE_LB_BIT] = s_q.lb_remote;
    ctrl_view[port_irq_lb_pkg::TAIL_TAG_BIT] = s_q.tail_tag;
  end

  always_comb begin
    s_d = s_q;
    s_d.phy_st = HAS_PHY ? phy_irq : 1'b0;
    if (mask_wr && (reg_wdata[port_irq_lb_pkg::ACL_BIT] != s_q.mask_acl)) begin
      s_d.acl_st = 1'b0;
    end
    if (acl_irq_pulse) begin
      s_d.acl_st = 1'b1;
    end
    if (mask_wr) begin
      s_d.mask_acl = reg_wdata[port_irq_lb_pkg::ACL_BIT];
      s_d.mask_phy = reg_wdata[port_irq_lb_pkg::PHY_BIT];
    end
    if (reg_wr && hit(reg_addr, port_irq_lb_pkg::CTRL0_OFS)) begin
      s_d.lb_local = reg_wdata[port_irq_lb_pkg::LOCAL_LB_BIT];
      s_d.lb_remote = reg_wdata[port_irq_lb_pkg::REMOTE_LB_BIT];
      s_d.tail_tag = reg_wdata[port_irq_lb_pkg::TAIL_TAG_BIT];
    end
    if (reg_rd) begin
      if (hit(reg_addr, port_irq_lb_pkg::STATUS_OFS)) begin
        s_d.rdata = status_view;
      end else if (hit(reg_addr, port_irq_lb_pkg::MASK_OFS)) begin
        s_d.rdata = mask_view;
      end else if (hit(reg_addr, port_irq_lb_pkg::CTRL0_OFS)) begin
        s_d.rdata = ctrl_view;
      end else begin
        s_d.rdata = port_irq_lb_pkg::RDATA_RST;
      end
    end
    s_d.irq = (s_q.acl_st && !s_q.mask_acl) || (s_q.phy_st && !s_q.mask_phy);
    // Pin-side receive data arrives from outside this clock and is synchronised.
    s_d.rx_s1 = line_rx_data;
    s_d.rx_s2 = s_q.rx_s1;
    s_d.rxv_s1 = line_rx_valid;
    s_d.rxv_s2 = s_q.rxv_s1;
    if (s_q.lb_remote) begin
      s_d.ltx = s_q.rx_s2;
      s_d.ltx_v = s_q.rxv_s2;
    end else if (s_q.lb_local) begin
      s_d.ltx = '0;
      s_d.ltx_v = 1'b0;
    end else begin
      s_d.ltx = fabric_tx_data;
      s_d.ltx_v = fabric_tx_valid;
    end
    if (s_q.lb_local) begin
      s_d.frx = fabric_tx_data;
      s_d.frx_v = fabric_tx_valid;
    end else if (s_q.lb_remote) begin
      s_d.frx = '0;
      s_d.frx_v = 1'b0;
    end else begin
      s_d.frx = s_q.rx_s2;
      s_d.frx_v = s_q.rxv_s2;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_q = s_q.rdata;
  assign port_irq_q = s_q.irq;
  assign tail_tag_en_q = s_q.tail_tag;
  assign fabric_rx_data_q = s_q.frx;
  assign fabric_rx_valid_q = s_q.frx_v;
  assign line_tx_data_q = s_q.ltx;
  assign line_tx_valid_q = s_q.ltx_v;

  //////////////////////////////////////////////////////////////////////////////
  property p_phy_follow;
    @(posedge clk) disable iff (!arst_n) 1'b1 |=> s_q.phy_st == (HAS_PHY && $past(phy_irq));
  endproperty
  a_phy_follow: assert property (p_phy_follow) else $error("phy status wrong");

  property p_phy_absent;
    @(posedge clk) disable iff (!arst_n)
      reg_rd && !HAS_PHY && reg_addr == port_irq_lb_pkg::STATUS_OFS |=>
      !reg_rdata_q[port_irq_lb_pkg::PHY_BIT];
  endproperty
  a_phy_absent: assert property (p_phy_absent) else $error("phy bit set on mac port");

  property p_acl_set;
    @(posedge clk) disable iff (!arst_n) acl_irq_pulse |=> s_q.acl_st;
  endproperty
  a_acl_set: assert property (p_acl_set) else $error("acl event lost");

  property p_acl_hold;
    @(posedge clk) disable iff (!arst_n) s_q.acl_st && !mask_wr |=> s_q.acl_st;
  endproperty
  a_acl_hold: assert property (p_acl_hold) else $error("acl cleared without toggle");

  property p_acl_clear;
    @(posedge clk) disable iff (!arst_n)
      mask_wr && !acl_irq_pulse && (reg_wdata[0] != s_q.mask_acl) |=> !s_q.acl_st;
  endproperty
  a_acl_clear: assert property (p_acl_clear) else $error("acl not cleared on toggle");

  property p_irq;
    @(posedge clk) disable iff (!arst_n) 1'b1 |=>
      port_irq_q == (($past(s_q.acl_st) && !$past(s_q.mask_acl)) ||
                     ($past(s_q.phy_st) && !$past(s_q.mask_phy)));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt output wrong");

  property p_mask_store;
    @(posedge clk) disable iff (!arst_n) mask_wr |=> s_q.mask_acl == $past(reg_wdata[0]);
  endproperty
  a_mask_store: assert property (p_mask_store) else $error("mask not stored");

  property p_status_rsvd;
    @(posedge clk) disable iff (!arst_n)
      reg_rd && reg_addr == port_irq_lb_pkg::STATUS_OFS |=> reg_rdata_q[7:2] == 6'h00;
  endproperty
  a_status_rsvd: assert property (p_status_rsvd) else $error("status reserved bits set");

  property p_local;
    @(posedge clk) disable iff (!arst_n) s_q.lb_local && fabric_tx_valid |=>
      fabric_rx_valid_q && fabric_rx_data_q == $past(fabric_tx_data);
  endproperty
  a_local: assert property (p_local) else $error("local loop failed");

  property p_remote;
    @(posedge clk) disable iff (!arst_n) s_q.lb_remote && s_q.rxv_s2 |=>
      line_tx_valid_q && line_tx_data_q == $past(s_q.rx_s2);
  endproperty
  a_remote: assert property (p_remote) else $error("remote loop failed");

  property p_bypass;
    @(posedge clk) disable iff (!arst_n) s_q.lb_remote && !s_q.lb_local |=> !fabric_rx_valid_q;
  endproperty
  a_bypass: assert property (p_bypass) else $error("remote loop reached fabric");

endmodule

/* File: hdl/port_irq_lb_pkg.sv */
package port_irq_lb_pkg;
  // Register offsets within the per-port 0xN0xx page.
  localparam logic [7:0] STATUS_OFS = 8'h1b;
  localparam logic [7:0] MASK_OFS = 8'h1f;
  localparam logic [7:0] CTRL0_OFS = 8'h20;
  // Field positions.
  localparam int ACL_BIT = 0;
  localparam int PHY_BIT = 1;
  localparam int TAIL_TAG_BIT = 2;
  localparam int REMOTE_LB_BIT = 6;
  localparam int LOCAL_LB_BIT = 7;
  // Values after reset.
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] CTRL0_RST = 8'h00;
  localparam logic [7:0] RDATA_RST = 8'h00;
endpackage

/* File: testbench/port_irq_lb_bench.sv */
`timescale 1ns/1ns
module port_irq_lb_bench;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic phy_irq = 1'b0;
  logic acl_irq_pulse = 1'b0;
  logic [7:0] fab_d = 8'h00;
  logic [7:0] line_d = 8'h00;
  logic fab_v = 1'b0;
  logic line_v = 1'b0;
  logic [7:0] rdata, fab_q, line_q, v, w;
  logic irq, tt, fab_vq, line_vq;
  logic [7:0] rdata_m;
  logic irq_m;
  int n_errors = 0;
  int n_compared = 0;
  always #2 clk = ~clk;
  port_irq_lb port_irq_lb_inst (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_q(rdata),
    .phy_irq(phy_irq), .acl_irq_pulse(acl_irq_pulse), .port_irq_q(irq),
    .tail_tag_en_q(tt), .fabric_tx_data(fab_d), .fabric_tx_valid(fab_v),
    .fabric_rx_data_q(fab_q), .fabric_rx_valid_q(fab_vq), .line_rx_data(line_d),
    .line_rx_valid(line_v), .line_tx_data_q(line_q), .line_tx_valid_q(line_vq));
  // A copy without a PHY shares every input; only its status and interrupt are watched.
  if (1) begin : mac_only
    port_irq_lb #(.HAS_PHY(1'b0)) port_irq_lb_inst (.clk(clk), .arst_n(arst_n),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
      .reg_rdata_q(rdata_m), .phy_irq(phy_irq), .acl_irq_pulse(acl_irq_pulse),
      .port_irq_q(irq_m), .tail_tag_en_q(), .fabric_tx_data(fab_d),
      .fabric_tx_valid(fab_v), .fabric_rx_data_q(), .fabric_rx_valid_q(),
      .line_rx_data(line_d), .line_rx_valid(line_v), .line_tx_data_q(),
      .line_tx_valid_q());
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Inputs always move 1 ns after a rising edge, never on it.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd = 1'b1;
    cyc(1);
    reg_rd = 1'b0;
    cyc(1);
    d = rdata;
  endtask
  function automatic logic [7:0] ctrl_exp(input logic [7:0] d);
    return d & 8'hc4;
  endfunction
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #20000;
    n_errors++;
    test_done;
  end
  initial begin
    void'($urandom(32'hf15fdb0a));
    cyc(16);
    arst_n = 1'b1;
    cyc(1);
    rd(port_irq_lb_pkg::STATUS_OFS, v);
    chk(v, 8'h00);
    rd(port_irq_lb_pkg::MASK_OFS, v);
    chk(v, 8'h00);
    rd(port_irq_lb_pkg::CTRL0_OFS, v);
    chk(v, 8'h00);
    chk(8'(tt), 8'h00);
    $display("reset test done");
    repeat (4) begin
      w = 8'($urandom);
      wr(port_irq_lb_pkg::MASK_OFS, w);
      rd(port_irq_lb_pkg::MASK_OFS, v);
      chk(v, w & 8'h03);
      wr(port_irq_lb_pkg::CTRL0_OFS, w);
      chk(8'(tt), 8'(w[2]));
      rd(port_irq_lb_pkg::CTRL0_OFS, v);
      chk(v, ctrl_exp(w));
      wr(port_irq_lb_pkg::STATUS_OFS, w);
      rd(port_irq_lb_pkg::STATUS_OFS, v);
      chk(v, 8'h00);
    end
    wr(port_irq_lb_pkg::MASK_OFS, 8'h00);
    $display("register test done");
    phy_irq = 1'b1;
    cyc(3);
    chk(8'(irq), 8'h01);
    chk(8'(irq_m), 8'h00);
    rd(port_irq_lb_pkg::STATUS_OFS, v);
    chk(v, 8'h02);
    chk(rdata_m, 8'h00);
    wr(port_irq_lb_pkg::MASK_OFS, 8'h02);
    cyc(2);
    chk(8'(irq), 8'h00);
    phy_irq = 1'b0;
    wr(port_irq_lb_pkg::MASK_OFS, 8'h00);
    acl_irq_pulse = 1'b1;
    cyc(1);
    acl_irq_pulse = 1'b0;
    rd(port_irq_lb_pkg::STATUS_OFS, v);
    chk(v, 8'h01);
    chk(8'(irq), 8'h01);
    chk(rdata_m, 8'h01);
    chk(8'(irq_m), 8'h01);
    wr(port_irq_lb_pkg::MASK_OFS, 8'h00);
    rd(port_irq_lb_pkg::STATUS_OFS, v);
    chk(v, 8'h01);
    wr(port_irq_lb_pkg::MASK_OFS, 8'h01);
    cyc(1);
    wr(port_irq_lb_pkg::MASK_OFS, 8'h00);
    cyc(2);
    rd(port_irq_lb_pkg::STATUS_OFS, v);
    chk(v, 8'h00);
    chk(8'(irq), 8'h00);
    $display("interrupt test done");
    repeat (4) begin
      w = 8'($urandom);
      wr(port_irq_lb_pkg::CTRL0_OFS, 8'h80);
      fab_d = w;
      fab_v = 1'b1;
      cyc(1);
      fab_v = 1'b0;
      chk(fab_q, w);
      chk(8'(fab_vq), 8'h01);
      wr(port_irq_lb_pkg::CTRL0_OFS, 8'h40);
      line_d = ~w;
      line_v = 1'b1;
      fab_v = 1'b1;
      cyc(1);
      {line_v, fab_v} = 2'b00;
      chk(8'(fab_vq), 8'h00);
      cyc(2);
      chk(line_q, ~w);
      chk(8'(line_vq), 8'h01);
      chk(8'(fab_vq), 8'h00);
    end
    $display("loopback test done");
    test_done;
  end
endmodule
